// ---- dsd_diag_telegram.sv ----
// Purpose: Slave diagnosis telegram builder with AHB-Lite register access.
// Assumes: Event pulses and the accessing master address come from logic on I_CLK_SYS.
// Notes: Reads take one wait state; writes take none.
`timescale 1ns/1ns
module dsd_diag_telegram #(
  parameter logic [15:0] BUS_ORG_IDENT_NUMBER = dsd_pkg::IDENT_DEFAULT
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_EVT_FREEZE,
  input wire logic I_EVT_SYNC,
  input wire logic I_EVT_UNSUP_FUNC,
  input wire logic I_EVT_BAD_PARAM,
  input wire logic [7:0] I_ACC_MASTER,
  input wire logic I_TG_RD,
  input wire logic [5:0] I_TG_IDX,
  output logic [7:0] O_TG_DATA,
  output logic O_TG_VALID,
  output logic [5:0] O_TG_LEN
);
  dsd_pkg::dsd_bus_t bus_q;
  logic [11:0] addr_q;
  logic [31:0] rdata_q;
  logic long_form_q;
  logic status_msg_q;
  logic [7:0] alarm_slot_q;
  dsd_pkg::dsd_stat0_t stat0_sw_q;
  dsd_pkg::dsd_stat1_t stat1_sw_q;
  dsd_pkg::dsd_evt_t evt_q;
  dsd_pkg::dsd_evt_t evt_set;
  dsd_pkg::dsd_evt_t evt_clr;
  logic [7:0] param_master_q;
  dsd_pkg::dsd_modsrc_t mod_q;
  logic [31:0] slotmap_q [dsd_pkg::SLOT_WORDS];
  logic [63:0] fault_q;
  logic [7:0] tg_data_q;
  logic tg_valid_q;

  logic addr_phase;
  logic wr_now;
  logic [11:0] waddr;
  logic slot_hit;
  logic [1:0] slot_sel;
  logic wr_ctrl;
  logic wr_station;
  logic wr_events;
  logic wr_pmaster;
  logic wr_module;
  logic wr_slot;
  logic wr_fault_lo;
  logic wr_fault_hi;
  dsd_pkg::dsd_stat0_t stat0;
  dsd_pkg::dsd_stat1_t stat1;
  dsd_pkg::dsd_mod1_t mod1;
  dsd_pkg::dsd_mod2_t mod2;
  dsd_pkg::dsd_mod3_t mod3;
  logic line1_fault;
  logic [5:0] dev_start;
  logic [5:0] tg_len;
  logic [7:0] tg_byte;
  logic [5:0] doff;
  logic [5:0] soff;
  logic [7:0] slot_byte;
  logic [7:0] rd_idx_byte;
  logic [31:0] rd_mux;

  assign addr_phase = I_HSEL && I_HREADY &&
    (I_HTRANS == dsd_pkg::HTRANS_NONSEQ || I_HTRANS == dsd_pkg::HTRANS_SEQ);
  assign wr_now = (bus_q == dsd_pkg::BUS_WRITE);
  assign waddr = addr_q;

  // One decode per register; the slot window also serves the read mux
  assign slot_hit = (addr_q >= dsd_pkg::REG_SLOTMAP0) && (addr_q <= dsd_pkg::REG_SLOTMAP3) &&
    (addr_q[1:0] == 2'h0);
  assign slot_sel = 2'((addr_q - dsd_pkg::REG_SLOTMAP0) >> 2);
  assign wr_ctrl = wr_now && (waddr == dsd_pkg::REG_CTRL);
  assign wr_station = wr_now && (waddr == dsd_pkg::REG_STATION);
  assign wr_events = wr_now && (waddr == dsd_pkg::REG_EVENTS);
  assign wr_pmaster = wr_now && (waddr == dsd_pkg::REG_PARAM_MASTER);
  assign wr_module = wr_now && (waddr == dsd_pkg::REG_MODULE);
  assign wr_slot = wr_now && slot_hit;
  assign wr_fault_lo = wr_now && (waddr == dsd_pkg::REG_FAULT_LO);
  assign wr_fault_hi = wr_now && (waddr == dsd_pkg::REG_FAULT_HI);

  // Bus sequencing; reads stall one cycle so read data always comes from a flop
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      bus_q <= dsd_pkg::BUS_IDLE;
      addr_q <= 12'h000;
    end else begin
      case (bus_q)
        dsd_pkg::BUS_RD_WAIT: begin
          bus_q <= dsd_pkg::BUS_RD_DONE;
        end
        default: begin
          if (addr_phase) begin
            addr_q <= I_HADDR[dsd_pkg::ADDR_W-1:0];
            bus_q <= I_HWRITE ? dsd_pkg::BUS_WRITE : dsd_pkg::BUS_RD_WAIT;
          end else begin
            bus_q <= dsd_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Never an error response: unmapped addresses read zero and drop writes
  always_comb begin
    O_HREADYOUT = (bus_q != dsd_pkg::BUS_RD_WAIT);
    O_HRESP = 1'b0;
    O_HRDATA = rdata_q;
  end

  // Control register
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      long_form_q <= 1'b0;
      status_msg_q <= 1'b0;
      alarm_slot_q <= 8'h00;
    end else if (wr_ctrl) begin
      long_form_q <= I_HWDATA[0];
      status_msg_q <= I_HWDATA[1];
      alarm_slot_q <= I_HWDATA[15:8];
    end
  end

  // Software-held station flags; derived bits are overridden below
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      stat0_sw_q <= '0;
      stat1_sw_q <= '0;
      stat0_sw_q.not_ready <= 1'b1;
      stat1_sw_q.need_param <= 1'b1;
    end else if (wr_station) begin
      stat0_sw_q <= I_HWDATA[7:0];
      stat1_sw_q <= I_HWDATA[15:8];
    end
  end

  // Sticky events: write one to clear, a new event in the same cycle wins
  always_comb begin
    evt_set = '0;
    evt_set.freeze_rcvd = I_EVT_FREEZE;
    evt_set.sync_rcvd = I_EVT_SYNC;
    evt_set.unsup_func = I_EVT_UNSUP_FUNC;
    evt_set.bad_param = I_EVT_BAD_PARAM;
    evt_clr = '0;
    if (wr_events) begin
      evt_clr = I_HWDATA[3:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // Out-of-range addresses collapse to the not-parameterized code
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      param_master_q <= dsd_pkg::MASTER_NONE;
    end else if (wr_pmaster) begin
      if (I_HWDATA[7:0] <= dsd_pkg::MASTER_MAX) begin
        param_master_q <= I_HWDATA[7:0];
      end else begin
        param_master_q <= dsd_pkg::MASTER_NONE;
      end
    end
  end

  // Module fault sources are software levels; the status bytes derive from them
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mod_q <= '0;
    end else if (wr_module) begin
      mod_q <= I_HWDATA[4:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < dsd_pkg::SLOT_WORDS; i++) begin
        slotmap_q[i] <= 32'h00000000;
      end
    end else if (wr_slot) begin
      slotmap_q[slot_sel] <= I_HWDATA;
    end
  end

  // Slave fault bits, one per slave, written by the line supervisor software
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      fault_q <= 64'h0000000000000000;
    end else if (wr_fault_lo) begin
      fault_q[31:0] <= I_HWDATA;
    end else if (wr_fault_hi) begin
      fault_q[63:32] <= I_HWDATA;
    end
  end

  // Status byte assembly
  assign line1_fault = (|fault_q) | mod_q.apf;

  always_comb begin
    stat0 = '0;
    stat0.not_addressable = stat0_sw_q.not_addressable;
    stat0.not_ready = stat0_sw_q.not_ready;
    stat0.cfg_fault = stat0_sw_q.cfg_fault;
    stat0.ext_diag = line1_fault;
    stat0.unsup_func = evt_q.unsup_func;
    stat0.resp_uninterp = stat0_sw_q.resp_uninterp;
    stat0.bad_param = evt_q.bad_param;
    // All-ones when unparameterized matches no accessing master, so bit 7 reads one
    stat0.other_master = (I_ACC_MASTER != param_master_q);
    stat1 = '0;
    stat1.need_param = stat1_sw_q.need_param;
    stat1.static_diag = stat1_sw_q.static_diag;
    stat1.resp_mon = stat1_sw_q.resp_mon;
    stat1.deactivated = stat1_sw_q.deactivated;
    stat1.freeze_rcvd = evt_q.freeze_rcvd;
    stat1.sync_rcvd = evt_q.sync_rcvd;
    mod1 = '0;
    mod1.internal = mod_q.eeprom | mod_q.watchdog;
    mod1.external = line1_fault;
    mod1.mismatch = mod_q.mismatch;
    mod1.apf = mod_q.apf;
    mod1.group = mod1.internal | mod1.external | mod1.mismatch | mod1.apf;
    mod2 = '0;
    mod2.mismatch = mod_q.mismatch;
    mod2.offline = mod_q.offline;
    mod2.watchdog = mod_q.watchdog;
    mod3 = '0;
    mod3.eeprom = mod_q.eeprom;
  end

  // Section boundaries follow the chosen form
  assign dev_start = long_form_q ? dsd_pkg::LONG_DEV_START : dsd_pkg::SHORT_DEV_START;
  assign tg_len = long_form_q ? dsd_pkg::LONG_TG_LEN : dsd_pkg::SHORT_TG_LEN;

  // Telegram byte selected by the read index
  always_comb begin
    doff = I_TG_IDX - dev_start;
    soff = I_TG_IDX - dsd_pkg::ID_MAP_IDX;
    slot_byte = slotmap_q[soff[3:2]][8*soff[1:0] +: 8];
    tg_byte = dsd_pkg::BYTE_ZERO;
    if (I_TG_IDX <= dsd_pkg::HB_IDENT_LO) begin
      case (I_TG_IDX)
        dsd_pkg::HB_STAT0: tg_byte = stat0;
        dsd_pkg::HB_STAT1: tg_byte = stat1;
        dsd_pkg::HB_STAT2: tg_byte = dsd_pkg::BYTE_ZERO;
        dsd_pkg::HB_MASTER: tg_byte = param_master_q;
        dsd_pkg::HB_IDENT_HI: tg_byte = BUS_ORG_IDENT_NUMBER[15:8];
        dsd_pkg::HB_IDENT_LO: tg_byte = BUS_ORG_IDENT_NUMBER[7:0];
        default: tg_byte = dsd_pkg::BYTE_ZERO;
      endcase
    end else if (I_TG_IDX == dsd_pkg::ID_HDR_IDX) begin
      tg_byte = long_form_q ? dsd_pkg::ID_HDR_LONG : dsd_pkg::ID_HDR_SHORT;
    // Slot bytes past the first exist only in long form; short form reads zero there
    end else if (I_TG_IDX < dev_start) begin
      if (I_TG_IDX == dsd_pkg::ID_MAP_IDX) begin
        tg_byte = {slot_byte[7:3], slot_byte[2], slot_byte[1] | line1_fault, 1'b0};
      end else if (long_form_q) begin
        tg_byte = slot_byte;
      end else begin
        tg_byte = dsd_pkg::BYTE_ZERO;
      end
    end else if (I_TG_IDX < tg_len) begin
      case (doff)
        dsd_pkg::DOFF_LEN: tg_byte = dsd_pkg::DEV_LEN;
        dsd_pkg::DOFF_TYPE: tg_byte = status_msg_q ? dsd_pkg::TYPE_STATUS : dsd_pkg::TYPE_ALARM;
        dsd_pkg::DOFF_SLOT: tg_byte = alarm_slot_q;
        dsd_pkg::DOFF_RSV: tg_byte = dsd_pkg::BYTE_ZERO;
        dsd_pkg::DOFF_MS1: tg_byte = mod1;
        dsd_pkg::DOFF_FIX1C: tg_byte = dsd_pkg::FIX_1C;
        dsd_pkg::DOFF_MS2: tg_byte = mod2;
        dsd_pkg::DOFF_MS3: tg_byte = mod3;
        dsd_pkg::DOFF_FIX60: tg_byte = dsd_pkg::FIX_60;
        dsd_pkg::DOFF_FIX00: tg_byte = dsd_pkg::BYTE_ZERO;
        dsd_pkg::DOFF_FIX40: tg_byte = dsd_pkg::FIX_40;
        default: begin
          if (doff >= dsd_pkg::DOFF_FAULT && doff <= dsd_pkg::DOFF_LAST) begin
            tg_byte = fault_q[8*3'(doff - dsd_pkg::DOFF_FAULT) +: 8];
          end
        end
      endcase
    end
  end

  // Reads have no side effects, so the master may fetch any byte again
  // Telegram read port, answer one cycle after the request
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tg_data_q <= 8'h00;
      tg_valid_q <= 1'b0;
    end else begin
      tg_valid_q <= I_TG_RD;
      if (I_TG_RD) begin
        tg_data_q <= tg_byte;
      end
    end
  end

  assign O_TG_DATA = tg_data_q;
  assign O_TG_VALID = tg_valid_q;
  assign O_TG_LEN = tg_len;

  // Register read mux, sampled in the stall cycle
  assign rd_idx_byte = {2'b00, tg_len};
  always_comb begin
    rd_mux = 32'h00000000;
    if (slot_hit) begin
      rd_mux = slotmap_q[slot_sel];
    end else begin
      case (addr_q)
        dsd_pkg::REG_CTRL: rd_mux = {16'h0000, alarm_slot_q, 6'h00, status_msg_q, long_form_q};
        dsd_pkg::REG_STATION: rd_mux = {16'h0000, stat1_sw_q, stat0_sw_q};
        dsd_pkg::REG_EVENTS: rd_mux = {28'h0000000, evt_q};
        dsd_pkg::REG_PARAM_MASTER: rd_mux = {24'h000000, param_master_q};
        dsd_pkg::REG_MODULE: rd_mux = {27'h0000000, mod_q};
        dsd_pkg::REG_FAULT_LO: rd_mux = fault_q[31:0];
        dsd_pkg::REG_FAULT_HI: rd_mux = fault_q[63:32];
        dsd_pkg::REG_STATUS: rd_mux = {8'h00, rd_idx_byte, stat1, stat0};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdata_q <= 32'h00000000;
    end else if (bus_q == dsd_pkg::BUS_RD_WAIT) begin
      rdata_q <= rd_mux;
    end
  end
endmodule

// ---- dsd_pkg.sv ----
// Purpose: Shared constants and types for the slave diagnosis telegram builder.
// Assumes: One 125 MHz clock, AHB-Lite register access, 32-bit data.
// Notes: Byte indices are positions within the telegram.
package dsd_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATION = 12'h004;
  localparam logic [11:0] REG_EVENTS = 12'h008;
  localparam logic [11:0] REG_PARAM_MASTER = 12'h00c;
  localparam logic [11:0] REG_MODULE = 12'h010;
  localparam logic [11:0] REG_SLOTMAP0 = 12'h014;
  localparam logic [11:0] REG_SLOTMAP3 = 12'h020;
  localparam logic [11:0] REG_FAULT_LO = 12'h024;
  localparam logic [11:0] REG_FAULT_HI = 12'h028;
  localparam logic [11:0] REG_STATUS = 12'h02c;
  localparam int SLOT_WORDS = 4;
  // Header layout
  localparam logic [5:0] HB_STAT0 = 6'h00;
  localparam logic [5:0] HB_STAT1 = 6'h01;
  localparam logic [5:0] HB_STAT2 = 6'h02;
  localparam logic [5:0] HB_MASTER = 6'h03;
  localparam logic [5:0] HB_IDENT_HI = 6'h04;
  localparam logic [5:0] HB_IDENT_LO = 6'h05;
  localparam logic [5:0] ID_HDR_IDX = 6'h06;
  localparam logic [5:0] ID_MAP_IDX = 6'h07;
  localparam logic [5:0] SHORT_DEV_START = 6'h09;
  localparam logic [5:0] LONG_DEV_START = 6'h17;
  localparam logic [5:0] SHORT_TG_LEN = 6'h1c;
  localparam logic [5:0] LONG_TG_LEN = 6'h2a;
  // Device-related section offsets
  localparam logic [5:0] DOFF_LEN = 6'h00;
  localparam logic [5:0] DOFF_TYPE = 6'h01;
  localparam logic [5:0] DOFF_SLOT = 6'h02;
  localparam logic [5:0] DOFF_RSV = 6'h03;
  localparam logic [5:0] DOFF_MS1 = 6'h04;
  localparam logic [5:0] DOFF_FIX1C = 6'h05;
  localparam logic [5:0] DOFF_MS2 = 6'h06;
  localparam logic [5:0] DOFF_MS3 = 6'h07;
  localparam logic [5:0] DOFF_FIX60 = 6'h08;
  localparam logic [5:0] DOFF_FIX00 = 6'h09;
  localparam logic [5:0] DOFF_FIX40 = 6'h0a;
  localparam logic [5:0] DOFF_FAULT = 6'h0b;
  localparam logic [5:0] DOFF_LAST = 6'h12;
  // Fixed codes
  localparam logic [7:0] DEV_LEN = 8'h13;
  localparam logic [7:0] ID_HDR_SHORT = 8'h43;
  localparam logic [7:0] ID_HDR_LONG = 8'h51;
  localparam logic [7:0] TYPE_ALARM = 8'h01;
  localparam logic [7:0] TYPE_STATUS = 8'h81;
  localparam logic [7:0] FIX_1C = 8'h1c;
  localparam logic [7:0] FIX_60 = 8'h60;
  localparam logic [7:0] FIX_40 = 8'h40;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] MASTER_NONE = 8'hff;
  localparam logic [7:0] MASTER_MAX = 8'h7e;
  // Arbitrary neutral value, not a real assignment
  localparam logic [15:0] IDENT_DEFAULT = 16'h1234;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic other_master;
    logic bad_param;
    logic resp_uninterp;
    logic unsup_func;
    logic ext_diag;
    logic cfg_fault;
    logic not_ready;
    logic not_addressable;
  } dsd_stat0_t;

  typedef struct packed {
    logic deactivated;
    logic rsv6;
    logic sync_rcvd;
    logic freeze_rcvd;
    logic resp_mon;
    logic rsv2;
    logic static_diag;
    logic need_param;
  } dsd_stat1_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic apf;
    logic mismatch;
    logic external;
    logic internal;
    logic group;
  } dsd_mod1_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic watchdog;
    logic offline;
    logic rsv1;
    logic mismatch;
  } dsd_mod2_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic eeprom;
    logic [1:0] rsv0;
  } dsd_mod3_t;

  typedef struct packed {
    logic offline;
    logic mismatch;
    logic apf;
    logic watchdog;
    logic eeprom;
  } dsd_modsrc_t;

  typedef struct packed {
    logic sync_rcvd;
    logic freeze_rcvd;
    logic bad_param;
    logic unsup_func;
  } dsd_evt_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RD_WAIT,
    BUS_RD_DONE
  } dsd_bus_t;
endpackage

// ---- dsd_diag_telegram_assertions.sv ----
// Purpose: Port-level checks on the diagnosis telegram builder.
// Assumes: One clock, active-high asynchronous reset.
// Notes: Bound to every dsd_diag_telegram instance.
`timescale 1ns/1ns
module dsd_diag_telegram_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  input wire logic I_TG_RD,
  input wire logic [5:0] I_TG_IDX,
  input wire logic [7:0] O_TG_DATA,
  input wire logic O_TG_VALID,
  input wire logic [5:0] O_TG_LEN
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  sequence seq_rd_taken;
    I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
  endsequence
  sequence seq_wr_taken;
    I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
  endsequence
  sequence seq_one_wait;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  chk_read_wait: assert property (seq_rd_taken |=> seq_one_wait)
    else $error("read data phase not one wait state");
  chk_write_nowait: assert property (seq_wr_taken |=> O_HREADYOUT)
    else $error("write data phase stalled");
  chk_valid_next: assert property (I_TG_RD |=> O_TG_VALID)
    else $error("telegram byte not answered next cycle");
  chk_valid_pulse: assert property (!I_TG_RD |=> !O_TG_VALID)
    else $error("telegram valid without request");
  chk_len_form: assert property (O_TG_LEN == 6'h1c || O_TG_LEN == 6'h2a)
    else $error("telegram length not short or long form");
  chk_id_const: assert property (I_TG_RD && I_TG_IDX == 6'h06 |=>
    O_TG_DATA == (($past(O_TG_LEN) == 6'h2a) ? 8'h51 : 8'h43))
    else $error("byte 6 constant wrong for form");
  chk_dev_len: assert property (I_TG_RD && I_TG_IDX ==
    ((O_TG_LEN == 6'h2a) ? 6'h17 : 6'h09) |=> O_TG_DATA == 8'h13)
    else $error("device section length byte wrong");
  chk_past_end: assert property (I_TG_RD && I_TG_IDX >= O_TG_LEN |=> O_TG_DATA == 8'h00)
    else $error("byte beyond telegram not zero");
  chk_slot_unused: assert property (I_TG_RD && I_TG_IDX == 6'h07 |=> !O_TG_DATA[0])
    else $error("slot bitmap bit 0 set");
  chk_stat1_rsv: assert property (I_TG_RD && I_TG_IDX == 6'h01 |=>
    !O_TG_DATA[2] && !O_TG_DATA[6])
    else $error("reserved station bits set");
endmodule
bind dsd_diag_telegram dsd_diag_telegram_assertions u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
  .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT),
  .I_TG_RD(I_TG_RD), .I_TG_IDX(I_TG_IDX), .O_TG_DATA(O_TG_DATA),
  .O_TG_VALID(O_TG_VALID), .O_TG_LEN(O_TG_LEN));

// ---- dsd_dp_master_model.sv ----
// Purpose: Fieldbus master reading the diagnosis telegram byte by byte.
// Assumes: Answer arrives a few cycles after the request at most.
// Notes: Index wanders while idle so a stale index never looks valid.
`timescale 1ns/1ns
module dsd_dp_master_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_rd,
  output logic [5:0] o_idx
);
  logic [5:0] idx_q = 6'h00;
  logic [5:0] cnt_q = 6'h00;
  initial o_rd = 1'b0;
  always @(posedge i_clk) cnt_q <= cnt_q + 6'h01;
  assign o_idx = o_rd ? idx_q : cnt_q;
  task automatic read_byte(input logic [5:0] k, output logic [7:0] b);
    int n;
    idx_q <= k;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_valid !== 1'b1 && n < 4);
    // A missing answer hands back unknown so the compare cannot pass
    b = (i_valid === 1'b1) ? i_data : 8'hxx;
  endtask
endmodule

// ---- dsd_diag_telegram_tb.sv ----
// Purpose: Self-checking bench for the diagnosis telegram builder.
// Assumes: Single bus slave, hready fed back from hreadyout.
// Notes: Random contents from a fixed seed; whole telegram compared each round.
`timescale 1ns/1ns
module dsd_diag_telegram_tb;
  // Arbitrary identification value
  localparam logic [15:0] ID = 16'h5a3c;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp, tg_rd, tg_valid;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [3:0] evt = 0, ev = 0;
  logic [7:0] acc = 8'h05, pm = 8'hff, d8, b;
  logic [5:0] tg_idx, tg_len;
  logic [7:0] tg_data;
  logic [31:0] ctl = 0, stn = 32'h102, md = 0, flo = 0, fhi = 0;
  logic [31:0] sm [4] = '{default: 0};
  int seed = 34, bad_count = 0, n_tests = 0, cyc = 0;
  dsd_diag_telegram #(.BUS_ORG_IDENT_NUMBER(ID)) dut (.I_CLK_SYS(clk), .I_RST(rst),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_EVT_FREEZE(evt[2]), .I_EVT_SYNC(evt[3]),
    .I_EVT_UNSUP_FUNC(evt[0]), .I_EVT_BAD_PARAM(evt[1]), .I_ACC_MASTER(acc),
    .I_TG_RD(tg_rd), .I_TG_IDX(tg_idx), .O_TG_DATA(tg_data), .O_TG_VALID(tg_valid),
    .O_TG_LEN(tg_len));
  dsd_dp_master_model u_m (.i_clk(clk), .i_valid(tg_valid), .i_data(tg_data),
    .o_rd(tg_rd), .o_idx(tg_idx));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Entered just after a clock edge; waits on hready with no assumed latency
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= dsd_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [7:0] exp_byte(input int k);
    logic lf;
    logic af;
    int dv;
    logic [63:0] f;
    logic [7:0] m1;
    logic [7:0] s0;
    lf = ctl[0];
    f = {fhi, flo};
    af = (|f) | md[2];
    dv = lf ? 23 : 9;
    s0 = sm[0][7:0];
    m1 = {3'h0, md[2], md[3], af, md[0] | md[1], 1'b0};
    m1[0] = |m1;
    if (k >= (lf ? 42 : 28)) return 8'h00;
    case (k)
      0: return {acc != pm, ev[1], stn[5], ev[0], af, stn[2:0]};
      1: return {stn[15], 1'b0, ev[3], ev[2], stn[11], 1'b0, stn[9:8]};
      2: return 8'h00;
      3: return pm;
      4: return ID[15:8];
      5: return ID[7:0];
      6: return lf ? 8'h51 : 8'h43;
      7: return {s0[7:2], s0[1] | af, 1'b0};
      default: ;
    endcase
    if (k < dv) return lf ? sm[(k - 7) / 4][8 * ((k - 7) % 4) +: 8] : 8'h00;
    case (k - dv)
      0: return 8'h13;
      1: return ctl[1] ? 8'h81 : 8'h01;
      2: return ctl[15:8];
      4: return m1;
      5: return 8'h1c;
      6: return {4'h0, md[1], md[4], 1'b0, md[3]};
      7: return {5'h0, md[0], 2'h0};
      8: return 8'h60;
      10: return 8'h40;
      default: return (k - dv > 10) ? f[8 * (k - dv - 11) +: 8] : 8'h00;
    endcase
  endfunction
  task automatic tg_all();
    for (int k = 0; k < 42; k++) begin
      u_m.read_byte(6'(k), b);
      chk(b, exp_byte(k));
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(tg_len, 6'h1c);
    bus(1'b0, dsd_pkg::REG_STATION, 0);
    chk(r, 32'h102);
    bus(1'b0, dsd_pkg::REG_PARAM_MASTER, 0);
    chk(r, 32'hff);
    bus(1'b1, 12'h030, 32'hffff_ffff);
    bus(1'b0, 12'h030, 0);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    tg_all();
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      ctl = $random(seed);
      ctl[0] = i[0];
      stn = $random(seed);
      md = $random(seed);
      flo = (i == 2) ? 0 : $random(seed);
      fhi = (i == 2) ? 0 : $random(seed);
      if (i == 2) md[2] = 1'b0;
      bus(1'b1, dsd_pkg::REG_CTRL, ctl);
      bus(1'b1, dsd_pkg::REG_STATION, stn);
      bus(1'b1, dsd_pkg::REG_MODULE, md);
      bus(1'b1, dsd_pkg::REG_FAULT_LO, flo);
      bus(1'b1, dsd_pkg::REG_FAULT_HI, fhi);
      for (int j = 0; j < 4; j++) begin
        sm[j] = $random(seed);
        bus(1'b1, dsd_pkg::REG_SLOTMAP0 + 12'(4 * j), sm[j]);
      end
      // Boundary addresses first, then random ones
      d8 = (i == 0) ? 8'h7e : (i == 1) ? 8'h7f : (i == 2) ? 8'h00 : 8'($random(seed));
      bus(1'b1, dsd_pkg::REG_PARAM_MASTER, {24'h0, d8});
      pm = (d8 > 8'h7e) ? 8'hff : d8;
      bus(1'b0, dsd_pkg::REG_PARAM_MASTER, 0);
      chk(r, {24'h0, pm});
      acc <= (i == 2) ? pm : 8'($unsigned($random(seed)) % 127);
      evt <= 4'($random(seed));
      @(posedge clk);
      ev = ev | evt;
      evt <= 4'h0;
      tg_all();
      bus(1'b0, dsd_pkg::REG_STATUS, 0);
      chk(r, {10'h0, ctl[0] ? 6'h2a : 6'h1c, exp_byte(1), exp_byte(0)});
      d8 = 8'($random(seed));
      bus(1'b1, dsd_pkg::REG_EVENTS, {28'h0, d8[3:0]});
      ev = ev & ~d8[3:0];
      bus(1'b0, dsd_pkg::REG_EVENTS, 0);
      chk(r, {28'h0, ev});
      $display("round %0d done", i);
    end
    // Event pulse in the very cycle of its clear: the event must win
    fork
      bus(1'b1, dsd_pkg::REG_EVENTS, 32'hf);
      begin
        @(posedge clk);
        evt <= 4'hf;
        @(posedge clk);
        evt <= 4'h0;
      end
    join
    bus(1'b0, dsd_pkg::REG_EVENTS, 0);
    chk(r, 32'hf);
    $display("event priority test done");
    report_and_stop();
  end
endmodule
